// *** rtl/cgr_pkg.sv ***
// ==========================================================
// Register map, field positions and reset values
package cgr_pkg;

  // ==========================================================
  // Bus geometry
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 32;

  // ==========================================================
  // Byte offsets
  localparam logic [6:0] OFF_SYS_SET = 7'h00;
  localparam logic [6:0] OFF_SYS_CLR = 7'h04;
  localparam logic [6:0] OFF_SYS_STATE = 7'h08;
  localparam logic [6:0] OFF_PER_SET = 7'h10;
  localparam logic [6:0] OFF_PER_CLR = 7'h14;
  localparam logic [6:0] OFF_PER_STATE = 7'h18;
  localparam logic [6:0] OFF_MAIN_FREQ = 7'h24;
  localparam logic [6:0] OFF_STATUS_CLR = 7'h50;
  localparam logic [6:0] OFF_IRQ_SET = 7'h60;
  localparam logic [6:0] OFF_IRQ_CLR = 7'h64;
  localparam logic [6:0] OFF_STATUS = 7'h68;
  localparam logic [6:0] OFF_IRQ_MASK = 7'h6c;

  // ==========================================================
  // Stored configuration words: oscillator, two PLLs, master
  // clock select, two programmable clock words
  localparam int unsigned CFG_N = 6;
  localparam logic [6:0] CFG_OFF [CFG_N] = '{7'h20, 7'h28, 7'h2c, 7'h30, 7'h40, 7'h44};
  localparam logic [31:0] CFG_MASK [CFG_N] = '{32'h0000ff03, 32'h27ffffff,
    32'h37ffffff, 32'h0000001f, 32'h0000001f, 32'h0000001f};
  localparam logic [31:0] CFG_RST [CFG_N] = '{32'h00000000, 32'h00003f00,
    32'h00003f00, 32'h00000000, 32'h00000000, 32'h00000000};
  localparam int unsigned CFG_MCK_IDX = 3;

  // ==========================================================
  // System clock bits
  localparam int unsigned SYS_PROC_BIT = 0;
  localparam int unsigned SYS_UHP_BIT = 6;
  localparam int unsigned SYS_UDP_BIT = 7;
  localparam int unsigned SYS_PROG_LSB = 8;
  localparam int unsigned PROG_N = 4;
  localparam logic [31:0] SYS_IMPL_MASK = 32'h00000fc1;
  localparam logic [31:0] SYS_STATE_RST = 32'h00000001;

  // ==========================================================
  // Peripheral clock bits
  localparam int unsigned PER_LSB = 2;
  localparam int unsigned PER_MSB = 29;
  localparam int unsigned BM_LSB = 26;
  localparam int unsigned BM_N = 4;
  localparam logic [31:0] PER_STATE_RST = 32'h00000000;

  // ==========================================================
  // Controller status and interrupt mask
  localparam int unsigned SR_MCK_RDY_BIT = 3;
  localparam int unsigned SR_PROG_RDY_LSB = 8;
  localparam logic [31:0] SR_IMPL_MASK = 32'h00000f08;
  localparam logic [31:0] SR_RST = 32'h00000008;
  localparam logic [31:0] IMR_RST = 32'h00000000;

  // ==========================================================
  // Bus handshake states
  typedef enum logic {
    CGR_BUS_IDLE,
    CGR_BUS_ACK
  } cgr_bus_e;

endpackage

// *** rtl/cgr_clk_gate.sv ***
`timescale 1ns/1ns
// ==========================================================
// Glitch-free clock gate: enable sampled on the falling edge,
// so the output can only change while the source clock is low
module cgr_clk_gate #(
  parameter bit RST_ON = 1'b0
) (
  input wire logic i_src_clk,
  input wire logic i_rstn,
  input wire logic i_en,
  output logic o_clk
);

  logic en_r;

  // Enable captured while the clock is low
  always_ff @(negedge i_src_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      en_r <= RST_ON;
    end else begin
      en_r <= i_en;
    end
  end

  // AND gate sees a stable enable across each high phase
  assign o_clk = i_src_clk & en_r;

endmodule // cgr_clk_gate

// *** rtl/cgr_clock_gate_regs.sv ***
`timescale 1ns/1ns
module cgr_clock_gate_regs
  import cgr_pkg::*;
#(
  parameter logic [31:0] PER_IMPL_MASK = 32'h3ffffffc
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_usb12_clk,
  input wire logic i_usb48_clk,
  input wire logic [PROG_N-1:0] i_prog_src_clk,
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [DATA_W-1:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [DATA_W-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_irq,
  output logic o_processor_idle,
  output logic o_processor_clk,
  output logic o_usb_host_clk12,
  output logic o_usb_host_clk48,
  output logic o_usb_device_clk48,
  output logic [PROG_N-1:0] o_prog_clk,
  output logic [BM_LSB-1:PER_LSB] o_periph_clk,
  output logic [BM_N-1:0] o_bus_master_clk,
  output logic [1:0] o_mck_source,
  output logic [2:0] o_mck_prescale
);

  // ==========================================================
  // Elaboration check
  generate
    if ((PER_IMPL_MASK & 32'hc0000003) != 32'h00000000) begin : g_bad_mask
      $error("peripheral mask sets bits outside 2..29");
    end
  endgenerate

  // ==========================================================
  // Helpers

  // Word address match, low two bits ignored
  function automatic logic hit(input logic [6:0] a, input logic [6:0] off);
    return a[6:2] == off[6:2];
  endfunction

  // Byte enables widened to a bit mask
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    logic [31:0] m;
    m = '0;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{be[b]}};
    end
    return m;
  endfunction

  // ==========================================================
  // Declarations
  cgr_bus_e bus_r;
  cgr_bus_e bus_nxt;
  logic req;
  logic wr_fire;
  logic rd_take;
  logic [31:0] wdata;
  logic [31:0] rdata_nxt;
  logic [31:0] rdata_r;
  logic [31:0] sys_en_r;
  logic [31:0] sys_en_nxt;
  logic [31:0] per_en_r;
  logic [31:0] per_en_nxt;
  logic [31:0] cfg_r [CFG_N];
  logic [31:0] sr_r;
  logic [31:0] sr_nxt;
  logic [31:0] sr_evt;
  logic [31:0] imr_r;
  logic [31:0] imr_nxt;
  logic mck_wr_r;
  logic [PROG_N-1:0] prog_prev_r;
  logic irq_nxt;
  logic irq_r;

  // ==========================================================
  // Avalon-MM handshake: one wait cycle, then the answer

  // Request present on the bus
  assign req = i_avs_read | i_avs_write;

  // Waitrequest held high for the first cycle of every request
  assign o_avs_waitrequest = req & (bus_r == CGR_BUS_IDLE);

  // Write lands on the edge where waitrequest is sampled low
  assign wr_fire = i_avs_write & (bus_r == CGR_BUS_ACK);

  // Read data captured on the edge that enters the answer cycle
  assign rd_take = i_avs_read & (bus_r == CGR_BUS_IDLE);

  // Write data with disabled byte lanes forced to zero
  assign wdata = i_avs_writedata & be_mask(i_avs_byteenable);

  // Handshake state step
  always_comb begin
    bus_nxt = bus_r;
    unique case (bus_r)
      CGR_BUS_IDLE: begin
        if (req) begin
          bus_nxt = CGR_BUS_ACK;
        end
      end
      CGR_BUS_ACK: begin
        bus_nxt = CGR_BUS_IDLE;
      end
    endcase
  end

  // Handshake state register
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      bus_r <= CGR_BUS_IDLE;
    end else begin
      bus_r <= bus_nxt;
    end
  end

  // ==========================================================
  // System clock enables

  // Set word turns clocks on, clear word turns them off
  always_comb begin
    sys_en_nxt = sys_en_r;
    if (wr_fire && hit(i_avs_address, OFF_SYS_SET)) begin
      sys_en_nxt = sys_en_r | (wdata & SYS_IMPL_MASK);
    end
    if (wr_fire && hit(i_avs_address, OFF_SYS_CLR)) begin
      sys_en_nxt = sys_en_r & ~(wdata & SYS_IMPL_MASK);
    end
    // Unmasked pending interrupt wakes the processor from idle
    if (irq_r) begin
      sys_en_nxt[SYS_PROC_BIT] = 1'b1;
    end
  end

  // System enable flops
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sys_en_r <= SYS_STATE_RST;
    end else begin
      sys_en_r <= sys_en_nxt;
    end
  end

  assign o_processor_idle = ~sys_en_r[SYS_PROC_BIT];

  // ==========================================================
  // Peripheral and bus-master clock enables

  // Only implemented identifiers can change
  always_comb begin
    per_en_nxt = per_en_r;
    if (wr_fire && hit(i_avs_address, OFF_PER_SET)) begin
      per_en_nxt = per_en_r | (wdata & PER_IMPL_MASK);
    end
    if (wr_fire && hit(i_avs_address, OFF_PER_CLR)) begin
      per_en_nxt = per_en_r & ~(wdata & PER_IMPL_MASK);
    end
  end

  // Peripheral enable flops
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      per_en_r <= PER_STATE_RST;
    end else begin
      per_en_r <= per_en_nxt;
    end
  end

  // ==========================================================
  // Configuration words

  // Each word keeps only its defined fields
  generate
    for (genvar g = 0; g < CFG_N; g++) begin : g_cfg
      always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          cfg_r[g] <= CFG_RST[g];
        end else if (wr_fire && hit(i_avs_address, CFG_OFF[g])) begin
          cfg_r[g] <= (cfg_r[g] & ~be_mask(i_avs_byteenable) & CFG_MASK[g])
            | (wdata & CFG_MASK[g]);
        end
      end
    end
  endgenerate

  // Master clock selection fields to the clock generator
  assign o_mck_source = cfg_r[CFG_MCK_IDX][1:0];
  assign o_mck_prescale = cfg_r[CFG_MCK_IDX][4:2];

  // ==========================================================
  // Status events and interrupt

  // Remember a master clock write and programmable enables
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mck_wr_r <= 1'b0;
      prog_prev_r <= '0;
    end else begin
      mck_wr_r <= wr_fire && hit(i_avs_address, CFG_OFF[CFG_MCK_IDX]);
      prog_prev_r <= sys_en_r[SYS_PROG_LSB +: PROG_N];
    end
  end

  // Ready after a master clock change, ready on each programmable output turned on
  always_comb begin
    sr_evt = '0;
    sr_evt[SR_MCK_RDY_BIT] = mck_wr_r;
    sr_evt[SR_PROG_RDY_LSB +: PROG_N] = sys_en_r[SYS_PROG_LSB +: PROG_N] & ~prog_prev_r;
  end

  // Sticky status: write one clears, a new event wins over the clear
  always_comb begin
    sr_nxt = sr_r;
    if (wr_fire && hit(i_avs_address, OFF_STATUS_CLR)) begin
      sr_nxt = sr_r & ~wdata;
    end
    sr_nxt = (sr_nxt | sr_evt) & SR_IMPL_MASK;
  end

  // Status flops
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sr_r <= SR_RST;
    end else begin
      sr_r <= sr_nxt;
    end
  end

  // Mask: enable word sets, disable word clears
  always_comb begin
    imr_nxt = imr_r;
    if (wr_fire && hit(i_avs_address, OFF_IRQ_SET)) begin
      imr_nxt = imr_r | (wdata & SR_IMPL_MASK);
    end
    if (wr_fire && hit(i_avs_address, OFF_IRQ_CLR)) begin
      imr_nxt = imr_r & ~wdata;
    end
  end

  // Mask flops
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      imr_r <= IMR_RST;
    end else begin
      imr_r <= imr_nxt;
    end
  end

  // Level interrupt while any unmasked status bit is set
  assign irq_nxt = |(sr_nxt & imr_nxt);

  // Interrupt output flop
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  assign o_irq = irq_r;

  // ==========================================================
  // Read path

  // Register select; unmapped and write-only words read zero
  always_comb begin
    rdata_nxt = '0;
    if (hit(i_avs_address, OFF_SYS_STATE)) begin
      rdata_nxt = sys_en_r & SYS_IMPL_MASK;
    end
    if (hit(i_avs_address, OFF_PER_STATE)) begin
      rdata_nxt = per_en_r & PER_IMPL_MASK;
    end
    if (hit(i_avs_address, OFF_MAIN_FREQ)) begin
      rdata_nxt = '0;
    end
    for (int c = 0; c < CFG_N; c++) begin
      if (hit(i_avs_address, CFG_OFF[c])) begin
        rdata_nxt = cfg_r[c];
      end
    end
    if (hit(i_avs_address, OFF_STATUS)) begin
      rdata_nxt = sr_r;
    end
    if (hit(i_avs_address, OFF_IRQ_MASK)) begin
      rdata_nxt = imr_r;
    end
  end

  // Read data held until the next read is taken
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_r <= '0;
    end else if (rd_take) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign o_avs_readdata = rdata_r;

  // ==========================================================
  // Clock gates

  // Processor clock runs from reset
  cgr_clk_gate #(
    .RST_ON(1'b1)
  ) u_proc_gate (
    .i_src_clk(i_clk),
    .i_rstn(i_rstn),
    .i_en(sys_en_r[SYS_PROC_BIT]),
    .o_clk(o_processor_clk)
  );

  // Host port: both clocks share one enable
  cgr_clk_gate u_uhp12_gate (
    .i_src_clk(i_usb12_clk),
    .i_rstn(i_rstn),
    .i_en(sys_en_r[SYS_UHP_BIT]),
    .o_clk(o_usb_host_clk12)
  );

  cgr_clk_gate u_uhp48_gate (
    .i_src_clk(i_usb48_clk),
    .i_rstn(i_rstn),
    .i_en(sys_en_r[SYS_UHP_BIT]),
    .o_clk(o_usb_host_clk48)
  );

  // Device port clock
  cgr_clk_gate u_udp_gate (
    .i_src_clk(i_usb48_clk),
    .i_rstn(i_rstn),
    .i_en(sys_en_r[SYS_UDP_BIT]),
    .o_clk(o_usb_device_clk48)
  );

  generate
    // Programmable outputs
    for (genvar p = 0; p < PROG_N; p++) begin : g_prog
      cgr_clk_gate u_gate (
        .i_src_clk(i_prog_src_clk[p]),
        .i_rstn(i_rstn),
        .i_en(sys_en_r[SYS_PROG_LSB+p]),
        .o_clk(o_prog_clk[p])
      );
    end
    // Peripheral clocks from the master clock
    for (genvar q = PER_LSB; q < BM_LSB; q++) begin : g_per
      cgr_clk_gate u_gate (
        .i_src_clk(i_clk),
        .i_rstn(i_rstn),
        .i_en(per_en_r[q]),
        .o_clk(o_periph_clk[q])
      );
    end
    // Bus-master clocks A to D
    for (genvar m = 0; m < BM_N; m++) begin : g_bm
      cgr_clk_gate u_gate (
        .i_src_clk(i_clk),
        .i_rstn(i_rstn),
        .i_en(per_en_r[BM_LSB+m]),
        .o_clk(o_bus_master_clk[m])
      );
    end
  endgenerate

endmodule // cgr_clock_gate_regs

// *** verification/cgr_regs_properties.sv ***
`timescale 1ns/1ns
// ==========================================================
// Bus timing, readback and gating checks on the top ports
module cgr_regs_properties
  import cgr_pkg::*;
#(
  parameter logic [31:0] PER_IMPL_MASK = 32'h3ffffffc
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [DATA_W-1:0] i_avs_writedata,
  input wire logic [DATA_W-1:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic o_irq,
  input wire logic o_processor_idle,
  input wire logic o_processor_clk,
  input wire logic [1:0] o_mck_source,
  input wire logic [2:0] o_mck_prescale
);
  logic acc_rd;
  logic acc_wr;
  // Accepted transfers
  assign acc_rd = i_avs_read && !o_avs_waitrequest;
  assign acc_wr = i_avs_write && !o_avs_waitrequest;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // ==========================================================
  // Assertions
  a_one_wait: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=>
    !o_avs_waitrequest) else $error("waitrequest held past one cycle");
  a_idle_nowait: assert property (!(i_avs_read || i_avs_write) |-> !o_avs_waitrequest)
    else $error("waitrequest without request");
  a_wo_zero: assert property (acc_rd && i_avs_address inside {7'h00, 7'h04, 7'h0c, 7'h10,
    7'h14, 7'h60, 7'h64} |-> o_avs_readdata == 32'h0) else $error("write-only word not zero");
  a_sys_reserved: assert property (acc_rd && i_avs_address == OFF_SYS_STATE |->
    (o_avs_readdata & ~SYS_IMPL_MASK) == 32'h0) else $error("system reserved bit set");
  a_per_reserved: assert property (acc_rd && i_avs_address == OFF_PER_STATE |->
    (o_avs_readdata & ~PER_IMPL_MASK) == 32'h0) else $error("peripheral reserved bit set");
  a_idle_entry: assert property (acc_wr && i_avs_address == OFF_SYS_CLR &&
    i_avs_writedata[0] && !o_irq |-> ##[1:2] o_processor_idle) else $error("no idle entry");
  a_irq_wake: assert property (o_irq [*3] |-> !o_processor_idle)
    else $error("pending interrupt left processor idle");
  a_irq_off: assert property (acc_wr && i_avs_address == OFF_IRQ_CLR &&
    i_avs_writedata == 32'h00000f08 |-> ##2 !o_irq) else $error("irq stayed high");
  a_mck_fields: assert property (acc_wr && i_avs_address == 7'h30 |-> ##2
    o_mck_source == $past(i_avs_writedata[1:0], 2) &&
    o_mck_prescale == $past(i_avs_writedata[4:2], 2)) else $error("master clock fields wrong");
  a_proc_gate: assert property (@(negedge i_clk) disable iff (!i_rstn)
    o_processor_idle && $past(o_processor_idle) |-> !o_processor_clk)
    else $error("processor clock runs while idle");
  // Main scenarios
  c_per_read: cover property (acc_rd && i_avs_address == OFF_PER_STATE);
  c_irq_pulse: cover property (o_irq ##1 !o_irq);
  c_idle: cover property ($rose(o_processor_idle));
endmodule // cgr_regs_properties

bind cgr_clock_gate_regs cgr_regs_properties #(.PER_IMPL_MASK(PER_IMPL_MASK)) cgr_regs_properties_i (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .o_irq(o_irq),
  .o_processor_idle(o_processor_idle), .o_processor_clk(o_processor_clk),
  .o_mck_source(o_mck_source), .o_mck_prescale(o_mck_prescale));

// *** verification/testbench.sv ***
`timescale 1ns/1ns
// ==========================================================
// Register and gate bench driven over the Avalon slave port
module testbench;
  import cgr_pkg::*;
  localparam logic [31:0] PMASK = 32'h3fff7ffc;
  logic i_clk = 0, i_rstn = 0, i_usb12_clk = 0, i_usb48_clk = 0;
  logic [3:0] i_prog_src_clk = 4'h0;
  logic [6:0] i_avs_address = 7'h00;
  logic i_avs_read = 0, i_avs_write = 0;
  logic [31:0] i_avs_writedata = 32'h0;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest, o_irq, o_processor_idle, o_processor_clk;
  logic o_usb_host_clk12, o_usb_host_clk48, o_usb_device_clk48;
  logic [3:0] o_prog_clk, o_bus_master_clk;
  logic [25:2] o_periph_clk;
  logic [1:0] o_mck_source;
  logic [2:0] o_mck_prescale;
  logic [31:0] exp_q[$];
  logic [31:0] st, s, c;
  int bad_count = 0, checks = 0;
  logic [6:0] ra[10] = '{7'h08, 7'h18, 7'h68, 7'h6c, 7'h28, 7'h2c, 7'h20, 7'h24, 7'h0c, 7'h00};
  logic [31:0] rv[10] = '{32'h1, 32'h0, 32'h8, 32'h0, 32'h3f00, 32'h3f00, 32'h0, 32'h0, 32'h0,
    32'h0};

  cgr_clock_gate_regs #(.PER_IMPL_MASK(PMASK)) cgr_clock_gate_regs_i (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_usb12_clk(i_usb12_clk), .i_usb48_clk(i_usb48_clk),
    .i_prog_src_clk(i_prog_src_clk), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(4'hf),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .o_irq(o_irq),
    .o_processor_idle(o_processor_idle), .o_processor_clk(o_processor_clk),
    .o_usb_host_clk12(o_usb_host_clk12), .o_usb_host_clk48(o_usb_host_clk48),
    .o_usb_device_clk48(o_usb_device_clk48), .o_prog_clk(o_prog_clk),
    .o_periph_clk(o_periph_clk), .o_bus_master_clk(o_bus_master_clk),
    .o_mck_source(o_mck_source), .o_mck_prescale(o_mck_prescale));

  // ==========================================================
  // Clocks: master clock and unrelated source clocks
  initial begin
    forever #50 i_clk = ~i_clk;
  end
  initial begin
    forever #10 i_usb48_clk = ~i_usb48_clk;
  end
  initial begin
    forever #41 i_usb12_clk = ~i_usb12_clk;
  end
  initial begin
    forever #17 i_prog_src_clk = ~i_prog_src_clk;
  end

  // ==========================================================
  // Shared tasks
  task check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One transfer; a read notes its expected data for the monitor
  // Request held until waitrequest is sampled low at a rising edge
  task bus(input bit rd, input logic [6:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_avs_address <= a;
    i_avs_writedata <= d;
    if (rd) begin
      exp_q.push_back(d);
      i_avs_read <= 1'b1;
    end else begin
      i_avs_write <= 1'b1;
    end
    do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask

  // Gated clock outputs against the expected enables
  task gates(input logic [31:0] sys, input logic [31:0] per);
    @(posedge i_usb48_clk);
    #1;
    check(o_usb_host_clk48, sys[6]);
    check(o_usb_device_clk48, sys[7]);
    @(posedge i_usb12_clk);
    #1;
    check(o_usb_host_clk12, sys[6]);
    @(posedge i_prog_src_clk[0]);
    #1;
    check(o_prog_clk, sys[11:8]);
    @(posedge i_clk);
    #20;
    check(o_processor_clk, sys[0]);
    check(o_periph_clk, per[25:2]);
    check(o_bus_master_clk, per[29:26]);
  endtask

  task end_of_test;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Read monitor: compares accepted read data with the oldest note
  always @(posedge i_clk) begin
    if (i_avs_read === 1'b1 && o_avs_waitrequest === 1'b0) begin
      check(o_avs_readdata, exp_q.pop_front());
    end
  end

  // Watchdog
  initial begin
    #(100 * 20000);
    bad_count++;
    end_of_test();
  end

  // ==========================================================
  // Main sequence
  initial begin
    s = $urandom(76);
    st = 32'h0;
    repeat (8) @(posedge i_clk);
    i_rstn <= 1'b1;
    for (int i = 0; i < 10; i++) bus(1, ra[i], rv[i]);
    check(o_processor_idle, 1'b0);
    $display("test reset done");
    bus(0, 7'h00, 32'h000000c0);
    bus(1, 7'h08, 32'h000000c1);
    bus(0, 7'h00, 32'h00000500);
    bus(1, 7'h08, 32'h000005c1);
    gates(32'h5c1, 32'h0);
    bus(0, 7'h04, 32'h00000140);
    bus(0, 7'h00, 32'hfffff000);
    bus(1, 7'h08, 32'h00000481);
    gates(32'h481, 32'h0);
    bus(0, 7'h04, 32'h00000fc0);
    bus(1, 7'h08, 32'h00000001);
    $display("test system gates done");
    bus(0, 7'h04, 32'h00000001);
    repeat (3) @(posedge i_clk);
    #1;
    check(o_processor_idle, 1'b1);
    bus(1, 7'h08, 32'h00000000);
    gates(32'h0, 32'h0);
    bus(0, 7'h00, 32'h00000001);
    bus(1, 7'h08, 32'h00000001);
    $display("test processor idle done");
    for (int i = 0; i < 5; i++) begin
      s = (i == 0) ? 32'h24000000 : $urandom;
      c = (i == 0) ? 32'h0 : $urandom;
      bus(0, 7'h10, s);
      st = st | (s & PMASK);
      bus(0, 7'h14, c);
      st = st & ~c;
      bus(1, 7'h18, st);
      gates(32'h1, st);
    end
    $display("test peripheral gates done");
    bus(0, 7'h60, 32'h00000008);
    repeat (2) @(posedge i_clk);
    #1;
    check(o_irq, 1'b1);
    bus(1, 7'h6c, 32'h00000008);
    bus(0, 7'h50, 32'h00000008);
    bus(1, 7'h68, 32'h00000500);
    check(o_irq, 1'b0);
    bus(0, 7'h30, 32'h00000015);
    bus(1, 7'h30, 32'h00000015);
    check(o_irq, 1'b1);
    check(o_mck_source, 2'h1);
    check(o_mck_prescale, 3'h5);
    bus(0, 7'h04, 32'h00000001);
    repeat (4) @(posedge i_clk);
    #1;
    check(o_processor_idle, 1'b0);
    bus(0, 7'h64, 32'h00000f08);
    bus(1, 7'h6c, 32'h00000000);
    check(o_irq, 1'b0);
    $display("test interrupt done");
    end_of_test();
  end
endmodule // testbench
